// file: verilog/sbu_pkg.sv
// Purpose: shared constants and carriers for the serial board uart
// Assumes: 100 MHz clk, processor bus on the same clock
// Notes: every offset, bit position and timing count lives here
package sbu_pkg;

   // ***************************************************************
   // channel decode and status word layout
   // ***************************************************************
   localparam logic CTRL_CHANNEL = 1'b0;
   localparam int ST_OUT_NOT_READY = 7;
   localparam int ST_RX_AVAIL = 5;
   localparam int ST_OVERRUN = 4;
   localparam int ST_FRAMING = 3;
   localparam int ST_PARITY = 2;
   localparam int ST_TX_ROOM = 1;
   localparam int ST_IN_NOT_READY = 0;
   localparam int EN_INPUT_BIT = 0;
   localparam int EN_OUTPUT_BIT = 1;
   localparam logic [7:0] ZERO_BYTE = 8'h00;

   // ***************************************************************
   // timing: 16x bit clock from a 0.5 us counter time base
   // ***************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int BASE_TICK_NS = 500;
   localparam int PRESCALE_CYCLES = BASE_TICK_NS / CLK_PERIOD_NS;
   localparam int MAX_BIT_CLOCK_KHZ = 400;
   localparam int MIN_SPAN = 1000000 / (MAX_BIT_CLOCK_KHZ * BASE_TICK_NS);
   localparam logic [11:0] TERMINAL_COUNT = 12'hFFF;
   localparam logic [11:0] MAX_PRESET = 12'(4096 - MIN_SPAN);
   localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
   localparam logic [3:0] START_MID = 4'h7;

   // ***************************************************************
   // carriers
   // ***************************************************************
   typedef struct packed {
      logic parity_off;
      logic two_stops;
      logic [1:0] length;
      logic even;
   } sbu_frame_t;

   typedef struct packed {
      logic [7:0] base_addr;
      logic [11:0] preset;
      sbu_frame_t frame;
      logic power_on_clear;
      logic serial_rx;
      logic input_ready_pulse;
      logic output_ready_pulse;
   } sbu_pins_t;

   // data bits per character is five plus the length code
   function automatic logic [2:0] sbu_last_bit(input logic [1:0] len);
      sbu_last_bit = 3'(len) + 3'h4;
   endfunction

   // parity bit over the bits that the length code keeps
   function automatic logic sbu_parity(input logic [7:0] d,
                                       input sbu_frame_t f);
      logic [7:0] m;
      m = d & (8'hFF >> (3'h3 - 3'(f.length)));
      sbu_parity = f.even ? ^m : ~^m;
   endfunction

endpackage

// file: verilog/sbu_bit_clock.sv
// Purpose: 16x bit clock from a presettable 12-bit counter
// Assumes: preset already synchronised
// Notes: output is a one-cycle pulse
`timescale 1ns/10ps
module sbu_bit_clock (
   input wire logic clk,
   input wire logic rst,
   input wire logic [11:0] preset,
   output logic tick16
);
   logic [5:0] pre;
   logic [11:0] count;
   logic base_tick;
   logic at_terminal;
   logic [11:0] safe_preset;

   // ***************************************************************
   // time base and limit
   // ***************************************************************
   // clamp keeps the bit clock at or under 400 kHz
   assign safe_preset = (preset > sbu_pkg::MAX_PRESET) ?
                        sbu_pkg::MAX_PRESET : preset;
   assign base_tick = (pre == 6'(sbu_pkg::PRESCALE_CYCLES - 1));
   assign at_terminal = (count == sbu_pkg::TERMINAL_COUNT);

   // prescaler to the 0.5 us counter time base
   always_ff @(posedge clk) begin
      if (rst || base_tick) begin
         pre <= 6'h00;
      end else begin
         pre <= pre + 6'h01;
      end
   end

   // counter reloads the preset on terminal count
   // reset parks it at terminal count: the first base tick reloads the
   // preset, so no full 4096-step run precedes the first bit tick
   always_ff @(posedge clk) begin
      if (rst) begin
         count <= sbu_pkg::TERMINAL_COUNT;
      end else if (base_tick) begin
         count <= at_terminal ? safe_preset : count + 12'h001;
      end
   end

   // one-shot shaper: a single clk-wide pulse per terminal count
   always_ff @(posedge clk) begin
      if (rst) begin
         tick16 <= 1'b0;
      end else begin
         tick16 <= base_tick && at_terminal;
      end
   end
endmodule

// file: verilog/sbu_pair_buffer.sv
// Purpose: two-entry byte buffer with valid/ready on both sides
// Assumes: single clock
// Notes: full and empty are exact, no word is dropped
`timescale 1ns/10ps
module sbu_pair_buffer (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [7:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_data
);
   logic [7:0] mem [2];
   logic wr_idx;
   logic rd_idx;
   logic [1:0] fill;
   logic push;
   logic pop;

   // ***************************************************************
   // handshake
   // ***************************************************************
   assign in_ready = (fill != 2'h2);
   assign out_valid = (fill != 2'h0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_idx];

   // storage written at the write index
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_idx] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk) begin
      if (rst) begin
         wr_idx <= 1'b0;
         rd_idx <= 1'b0;
         fill <= 2'h0;
      end else begin
         wr_idx <= wr_idx ^ push;
         rd_idx <= rd_idx ^ pop;
         fill <= fill + 2'(push) - 2'(pop);
      end
   end
endmodule

// file: verilog/sbu_uart.sv
// Purpose: serial port on a processor I/O bus, two channels
// Assumes: bus signals synchronous to clk; straps and line are pins
// Notes: transmit bytes wait in a two-entry buffer before the shifter
`timescale 1ns/10ps

// How it works
// - respond only when address bits 7 to 1 equal base bits 7 to 1
// - address bit zero picks control or data
// - control read drives status word onto bus
// - bit 7 low when output ready; irq
// - bit 5 high while received char unread
// - bit 4 flags overrun of unread char
// - bit 3 framing error, bit 2 parity
// - bit 1 high when another write fits
// - bit 0 low when input ready; 6 zero
// - control write latches two interrupt enables
// - data write loads and starts transmission
// - data write clears output-ready flip-flop
// - data read drives received character onto bus
// - data read clears input ready and available
// - both directions run on 16x tick
// - 12-bit reload counter plus one-shot shaper
// - bit clock limited to 400 kHz
// - parity strap high removes parity bit
// - stop strap picks one or two stops
// - length straps pick 5 to 8 bits
// - parity sense low odd, high even
// - three requests routed to eight levels
// - bus drivers off during power-on clear
module sbu_uart (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] bus_addr,
   input wire logic bus_in_cycle,
   input wire logic bus_out_cycle,
   input wire logic bus_write_n,
   input wire logic [7:0] bus_data_out,
   output logic [7:0] bus_data_in,
   output logic bus_data_in_oe_n,
   input wire logic [7:0] base_addr_strap,
   input wire logic [11:0] baud_preset_strap,
   input wire logic parity_suppress_strap,
   input wire logic stop_count_strap,
   input wire logic char_length_high_strap,
   input wire logic char_length_low_strap,
   input wire logic parity_sense_strap,
   input wire logic power_on_clear,
   input wire logic serial_rx,
   output logic serial_tx,
   input wire logic input_ready_pulse,
   input wire logic output_ready_pulse,
   output logic input_ready_flag,
   output logic output_ready_flag,
   output logic out_irq,
   output logic in_irq,
   output logic either_device_irq,
   input wire logic [2:0] out_irq_level,
   input wire logic [2:0] in_irq_level,
   input wire logic [2:0] either_irq_level,
   input wire logic [2:0] irq_route_en,
   output logic [7:0] priority_irq_lines
);
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY,
                             TX_STOP} sbu_tx_state_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY,
                             RX_STOP} sbu_rx_state_t;

   sbu_pkg::sbu_pins_t pins_raw;
   sbu_pkg::sbu_pins_t pins_meta;
   sbu_pkg::sbu_pins_t pins;
   logic in_pulse_q;
   logic out_pulse_q;
   logic tick16;

   // ***************************************************************
   // pin synchronisers
   // ***************************************************************
   assign pins_raw = '{base_addr: base_addr_strap,
                       preset: baud_preset_strap,
                       frame: '{parity_off: parity_suppress_strap,
                                two_stops: stop_count_strap,
                                length: {char_length_high_strap,
                                         char_length_low_strap},
                                even: parity_sense_strap},
                       power_on_clear: power_on_clear,
                       serial_rx: serial_rx,
                       input_ready_pulse: input_ready_pulse,
                       output_ready_pulse: output_ready_pulse};

   // two flops ahead of any logic; line idles high after reset
   always_ff @(posedge clk) begin
      if (rst) begin
         pins_meta <= '{serial_rx: 1'b1, default: '0};
         pins <= '{serial_rx: 1'b1, default: '0};
      end else begin
         pins_meta <= pins_raw;
         pins <= pins_meta;
      end
   end

   // ***************************************************************
   // address decode and bus strobes
   // ***************************************************************
   logic addr_match;
   logic ctrl_sel;
   logic data_sel;
   logic write_n_q;
   logic write_fall;
   logic data_rd_q;
   logic data_rd;
   logic data_rd_end;
   logic tx_load;
   logic ctrl_load;

   // base bit zero is ignored so the pair is always even/odd
   assign addr_match = (bus_addr[7:1] == pins.base_addr[7:1]);
   assign ctrl_sel = addr_match &&
                     (bus_addr[0] == sbu_pkg::CTRL_CHANNEL);
   assign data_sel = addr_match &&
                     (bus_addr[0] != sbu_pkg::CTRL_CHANNEL);
   assign write_fall = write_n_q && !bus_write_n;
   assign tx_load = write_fall && bus_out_cycle && data_sel;
   assign ctrl_load = write_fall && bus_out_cycle && ctrl_sel;
   assign data_rd = bus_in_cycle && data_sel;
   // clearing at the end keeps the data steady for the whole read
   assign data_rd_end = data_rd_q && !data_rd;

   // strobe edge and read-end detectors
   always_ff @(posedge clk) begin
      if (rst) begin
         write_n_q <= 1'b1;
         data_rd_q <= 1'b0;
      end else begin
         write_n_q <= bus_write_n;
         data_rd_q <= data_rd;
      end
   end

   // ***************************************************************
   // interrupt enables and device ready flip-flops
   // ***************************************************************
   logic in_en;
   logic out_en;
   logic in_ready_set;
   logic out_ready_set;

   assign in_ready_set = pins.input_ready_pulse && !in_pulse_q;
   assign out_ready_set = pins.output_ready_pulse && !out_pulse_q;

   // other data bits of a control write are ignored
   always_ff @(posedge clk) begin
      if (rst) begin
         in_en <= 1'b0;
         out_en <= 1'b0;
      end else if (ctrl_load) begin
         in_en <= bus_data_out[sbu_pkg::EN_INPUT_BIT];
         out_en <= bus_data_out[sbu_pkg::EN_OUTPUT_BIT];
      end
   end

   // a ready pulse in the clearing cycle wins over the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         in_pulse_q <= 1'b0;
         out_pulse_q <= 1'b0;
         input_ready_flag <= 1'b0;
         output_ready_flag <= 1'b0;
      end else begin
         in_pulse_q <= pins.input_ready_pulse;
         out_pulse_q <= pins.output_ready_pulse;
         if (in_ready_set) begin
            input_ready_flag <= 1'b1;
         end else if (data_rd_end) begin
            input_ready_flag <= 1'b0;
         end
         if (out_ready_set) begin
            output_ready_flag <= 1'b1;
         end else if (tx_load) begin
            output_ready_flag <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // interrupt requests and level routing
   // ***************************************************************
   assign out_irq = output_ready_flag && out_en;
   assign in_irq = input_ready_flag && in_en;
   assign either_device_irq = out_irq || in_irq;

   // each request drives the level its strap names, if routed
   for (genvar lv = 0; lv < 8; lv++) begin : g_level
      assign priority_irq_lines[lv] =
         (irq_route_en[0] && out_irq && out_irq_level == 3'(lv)) ||
         (irq_route_en[1] && in_irq && in_irq_level == 3'(lv)) ||
         (irq_route_en[2] && either_device_irq &&
          either_irq_level == 3'(lv));
   end

   // ***************************************************************
   // bit clock
   // ***************************************************************
   sbu_bit_clock u_bit_clock (
      .clk(clk),
      .rst(rst),
      .preset(pins.preset),
      .tick16(tick16)
   );

   // ***************************************************************
   // transmit path: buffer then shifter
   // ***************************************************************
   logic tx_room;
   logic tx_pend;
   logic [7:0] tx_pend_data;
   logic tx_take;
   sbu_tx_state_t tx_state;
   logic [3:0] tx_cnt;
   logic [2:0] tx_idx;
   logic [7:0] tx_shift;
   logic tx_stop2;
   logic tx_bit_end;

   // a write with no room is dropped; software polls the room bit
   sbu_pair_buffer u_tx_buffer (
      .clk(clk),
      .rst(rst),
      .in_valid(tx_load),
      .in_ready(tx_room),
      .in_data(bus_data_out),
      .out_valid(tx_pend),
      .out_ready(tx_take),
      .out_data(tx_pend_data)
   );

   assign tx_take = (tx_state == TX_IDLE) && tick16;
   assign tx_bit_end = tick16 && (tx_cnt == sbu_pkg::OVERSAMPLE_LAST);

   // sixteen ticks per bit on the line
   always_ff @(posedge clk) begin
      if (rst || tx_state == TX_IDLE) begin
         tx_cnt <= 4'h0;
      end else if (tick16) begin
         tx_cnt <= tx_cnt + 4'h1;
      end
   end

   // frame sequencer: start, data, parity, stops
   always_ff @(posedge clk) begin
      if (rst) begin
         tx_state <= TX_IDLE;
         tx_idx <= 3'h0;
         tx_shift <= sbu_pkg::ZERO_BYTE;
         tx_stop2 <= 1'b0;
         serial_tx <= 1'b1;
      end else begin
         unique case (tx_state)
            TX_IDLE: begin
               serial_tx <= 1'b1;
               if (tx_take && tx_pend) begin
                  tx_shift <= tx_pend_data;
                  tx_state <= TX_START;
                  serial_tx <= 1'b0;
               end
            end
            TX_START: begin
               if (tx_bit_end) begin
                  tx_idx <= 3'h0;
                  serial_tx <= tx_shift[0];
                  tx_state <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (tx_bit_end) begin
                  tx_idx <= tx_idx + 3'h1;
                  serial_tx <= tx_shift[3'(tx_idx + 3'h1)];
                  if (tx_idx == sbu_pkg::sbu_last_bit(pins.frame.length))
                  begin
                     tx_stop2 <= pins.frame.two_stops;
                     if (pins.frame.parity_off) begin
                        serial_tx <= 1'b1;
                        tx_state <= TX_STOP;
                     end else begin
                        serial_tx <= sbu_pkg::sbu_parity(tx_shift,
                                     pins.frame);
                        tx_state <= TX_PARITY;
                     end
                  end
               end
            end
            TX_PARITY: begin
               if (tx_bit_end) begin
                  serial_tx <= 1'b1;
                  tx_state <= TX_STOP;
               end
            end
            TX_STOP: begin
               if (tx_bit_end) begin
                  tx_stop2 <= 1'b0;
                  tx_state <= tx_stop2 ? TX_STOP : TX_IDLE;
               end
            end
         endcase
      end
   end

   // ***************************************************************
   // receive path
   // ***************************************************************
   sbu_rx_state_t rx_state;
   logic [3:0] rx_cnt;
   logic [2:0] rx_idx;
   logic [7:0] rx_shift;
   logic rx_par_bit;
   logic rx_sample;
   logic rx_done;
   logic [7:0] rx_hold;
   logic rx_avail;
   logic rx_overrun;
   logic rx_framing;
   logic rx_par_err;

   // mid-bit sample, sixteen ticks after the start centre
   assign rx_sample = tick16 && (rx_cnt == sbu_pkg::OVERSAMPLE_LAST);
   assign rx_done = (rx_state == RX_STOP) && rx_sample;

   // frame sequencer; start bit re-checked at its middle
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_state <= RX_IDLE;
         rx_cnt <= 4'h0;
         rx_idx <= 3'h0;
         rx_shift <= sbu_pkg::ZERO_BYTE;
         rx_par_bit <= 1'b0;
      end else begin
         if (tick16) begin
            rx_cnt <= rx_cnt + 4'h1;
         end
         unique case (rx_state)
            RX_IDLE: begin
               rx_cnt <= 4'h0;
               if (tick16 && !pins.serial_rx) begin
                  rx_state <= RX_START;
               end
            end
            RX_START: begin
               if (tick16 && rx_cnt == sbu_pkg::START_MID) begin
                  rx_cnt <= 4'h0;
                  rx_idx <= 3'h0;
                  rx_shift <= sbu_pkg::ZERO_BYTE;
                  rx_state <= pins.serial_rx ? RX_IDLE : RX_DATA;
               end
            end
            RX_DATA: begin
               if (rx_sample) begin
                  rx_shift[rx_idx] <= pins.serial_rx;
                  rx_idx <= rx_idx + 3'h1;
                  if (rx_idx == sbu_pkg::sbu_last_bit(pins.frame.length))
                  begin
                     rx_state <= pins.frame.parity_off ?
                                 RX_STOP : RX_PARITY;
                  end
               end
            end
            RX_PARITY: begin
               if (rx_sample) begin
                  rx_par_bit <= pins.serial_rx;
                  rx_state <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (rx_sample) begin
                  rx_state <= RX_IDLE;
               end
            end
         endcase
      end
   end

   // holding register and flags; a new character beats a read-end clear
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_hold <= sbu_pkg::ZERO_BYTE;
         rx_avail <= 1'b0;
         rx_overrun <= 1'b0;
         rx_framing <= 1'b0;
         rx_par_err <= 1'b0;
      end else if (rx_done) begin
         rx_hold <= rx_shift;
         rx_avail <= 1'b1;
         rx_overrun <= rx_avail && !data_rd_end;
         rx_framing <= !pins.serial_rx;
         rx_par_err <= !pins.frame.parity_off &&
            (rx_par_bit != sbu_pkg::sbu_parity(rx_shift,
                                              pins.frame));
      end else if (data_rd_end) begin
         rx_avail <= 1'b0;
         rx_overrun <= 1'b0;
      end
   end

   // ***************************************************************
   // read data path
   // ***************************************************************
   logic [7:0] status_word;
   logic status_word_output_enable;
   logic receive_output_enable;

   always_comb begin
      status_word = sbu_pkg::ZERO_BYTE; // unused bit 6 reads low
      status_word[sbu_pkg::ST_OUT_NOT_READY] = !output_ready_flag;
      status_word[sbu_pkg::ST_RX_AVAIL] = rx_avail;
      status_word[sbu_pkg::ST_OVERRUN] = rx_overrun;
      status_word[sbu_pkg::ST_FRAMING] = rx_framing;
      status_word[sbu_pkg::ST_PARITY] = rx_par_err;
      status_word[sbu_pkg::ST_TX_ROOM] = tx_room;
      status_word[sbu_pkg::ST_IN_NOT_READY] = !input_ready_flag;
   end

   assign status_word_output_enable = bus_in_cycle && ctrl_sel;
   assign receive_output_enable = data_rd;
   assign bus_data_in = receive_output_enable ? rx_hold :
                        status_word_output_enable ? status_word :
                        sbu_pkg::ZERO_BYTE;
   // drivers held off while power-on clear is asserted
   assign bus_data_in_oe_n = pins.power_on_clear ||
      !(status_word_output_enable || receive_output_enable);
endmodule

// file: test/sbu_uart_assertions.sv
// Purpose: port checks for the serial board uart
// Assumes: straps held steady while checked
// Notes: bound from the bench file
`timescale 1ns/10ps
module sbu_uart_assertions (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] bus_addr,
   input wire logic bus_in_cycle,
   input wire logic [7:0] bus_data_in,
   input wire logic bus_data_in_oe_n,
   input wire logic [7:0] base_addr_strap,
   input wire logic power_on_clear,
   input wire logic input_ready_flag,
   input wire logic output_ready_flag,
   input wire logic out_irq,
   input wire logic in_irq,
   input wire logic either_device_irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // channel selects; strap bit zero takes no part
   wire m = bus_addr[7:1] == base_addr_strap[7:1];
   wire st = bus_in_cycle && m && !bus_addr[0];
   wire dt = bus_in_cycle && m && bus_addr[0];
   a_drive_on_read: assert property (
      !bus_data_in_oe_n |-> bus_in_cycle && m) else $error("stray drive");
   a_foreign_quiet: assert property (
      bus_in_cycle && !m |-> bus_data_in_oe_n && bus_data_in == 8'h00)
      else $error("answered foreign address");
   a_status_bits: assert property (
      st && !bus_data_in_oe_n |-> bus_data_in[7] != output_ready_flag &&
      !bus_data_in[6] && bus_data_in[0] != input_ready_flag)
      else $error("status ready bits wrong");
   a_clear_hides: assert property (
      power_on_clear [*3] |-> bus_data_in_oe_n) else $error("drive in clear");
   a_read_clears: assert property (
      $fell(dt) |=> !input_ready_flag) else $error("input ready kept");
   a_in_gated: assert property (
      in_irq |-> input_ready_flag) else $error("input irq without ready");
   a_out_gated: assert property (
      out_irq |-> output_ready_flag) else $error("output irq without ready");
   a_either_or: assert property (
      either_device_irq == (in_irq || out_irq)) else $error("either wrong");
   // main scenarios reached
   cover property (st && !bus_data_in_oe_n);
   cover property (dt ##1 !dt);
   cover property (in_irq && either_device_irq);
endmodule

// file: test/sbu_term_model.sv
// Purpose: serial terminal at the far end of the line
// Assumes: 8 data bits, no parity, one stop bit
// Notes: line idles high between frames
`timescale 1ns/10ps
module sbu_term_model #(parameter int BIT = 4000) (
   input wire logic clk,
   input wire logic serial_tx,
   input wire logic go,
   input wire logic [7:0] go_byte,
   output logic serial_rx,
   output logic [7:0] got_byte
);
   // sender: one frame when go rises, 16 ticks a bit
   initial begin
      logic [9:0] fr;
      serial_rx = 1'h1;
      @(posedge go);
      fr = {1'h1, go_byte, 1'h0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk) serial_rx <= fr[i];
         repeat (BIT - 1) @(posedge clk);
      end
   end
   // receiver: centre sampling, lsb first
   initial forever begin
      @(negedge serial_tx);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge clk);
         got_byte[i] = serial_tx;
      end
   end
endmodule

// file: test/sbu_uart_bench.sv
// Purpose: bus tests for the serial board uart
// Assumes: 100 MHz clock, fastest preset, 8 bits no parity
// Notes: base address 8'h10, one character checked each way
`timescale 1ns/10ps
module sbu_uart_bench;
   localparam int BIT = 4000; // 16 ticks of 250 clocks at preset FFB
   logic clk = 1'h0;
   logic rst, bus_in_cycle, bus_out_cycle, bus_write_n, go;
   logic parity_suppress_strap, stop_count_strap, parity_sense_strap;
   logic char_length_high_strap, char_length_low_strap, power_on_clear;
   logic serial_rx, serial_tx, input_ready_pulse, output_ready_pulse;
   logic input_ready_flag, output_ready_flag, out_irq, in_irq;
   logic either_device_irq, bus_data_in_oe_n;
   logic [7:0] bus_addr, bus_data_out, bus_data_in, base_addr_strap;
   logic [7:0] priority_irq_lines, got_byte;
   logic [11:0] baud_preset_strap;
   logic [2:0] out_irq_level, in_irq_level, either_irq_level, irq_route_en;
   int num_errors = 0;
   int total_checks = 0;
   sbu_uart dut_u (.*);
   sbu_term_model #(.BIT(BIT)) term_u (.clk, .serial_tx, .go,
      .go_byte(8'h3C), .serial_rx, .got_byte);
   // four-state compare, so x never passes
   task automatic chk(input logic [11:0] g, input logic [11:0] e);
      total_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // read cycle; side effects land one clock after the select drops
   task automatic rd(input logic [7:0] ad, input logic [8:0] e);
      @(posedge clk) bus_addr <= ad;
      bus_in_cycle <= 1'h1;
      @(posedge clk) #1 chk({3'h0, bus_data_in_oe_n, bus_data_in}, {3'h0, e});
      @(posedge clk) bus_in_cycle <= 1'h0;
      @(posedge clk);
   endtask
   // write cycle; strobe returns high before the next one
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge clk) bus_addr <= ad;
      bus_data_out <= dt;
      bus_out_cycle <= 1'h1;
      @(posedge clk) bus_write_n <= 1'h0;
      @(posedge clk) bus_write_n <= 1'h1;
      bus_out_cycle <= 1'h0;
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial forever #5 clk = ~clk;
   // straps fixed; levels out 3, in 5, either 7, all routed
   initial begin
      {rst, bus_in_cycle, bus_out_cycle, bus_write_n, go} = 5'h12;
      {power_on_clear, input_ready_pulse, output_ready_pulse} = 3'h0;
      {parity_suppress_strap, stop_count_strap, char_length_high_strap,
         char_length_low_strap, parity_sense_strap} = 5'h16;
      {bus_addr, bus_data_out, base_addr_strap} = 24'h000010;
      {baud_preset_strap, irq_route_en} = 15'h7FDF;
      {out_irq_level, in_irq_level, either_irq_level} = 9'h0EF;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      repeat (3) @(posedge clk);
      rd(8'h10, 9'h083);
      rd(8'h20, 9'h100);
      output_ready_pulse <= 1'h1;
      repeat (6) @(posedge clk);
      output_ready_pulse <= 1'h0;
      wr(8'h10, 8'hFE);
      rd(8'h10, 9'h003);
      #1 chk({2'h0, out_irq, in_irq, priority_irq_lines}, 12'h288);
      input_ready_pulse <= 1'h1;
      repeat (6) @(posedge clk);
      input_ready_pulse <= 1'h0;
      wr(8'h10, 8'h01);
      #1 chk({2'h0, out_irq, in_irq, priority_irq_lines}, 12'h1A0);
      go <= 1'h1;
      wr(8'h11, 8'hA5);
      for (int n = 0; got_byte !== 8'hA5 && n < 50000; n++) @(posedge clk);
      chk({4'h0, got_byte}, 12'h0A5);
      if (got_byte !== 8'hA5) final_report();
      repeat (BIT + 200) @(posedge clk);
      rd(8'h10, 9'h0A2);
      rd(8'h11, 9'h03C);
      rd(8'h10, 9'h083);
      repeat (3) wr(8'h11, 8'h55);
      rd(8'h10, 9'h081);
      power_on_clear <= 1'h1;
      repeat (4) @(posedge clk);
      rd(8'h10, 9'h181);
      final_report();
   end
endmodule
bind sbu_uart sbu_uart_assertions chk_u (.*);
